//--- common/fsc_pkg.sv
// types shared by the status-2 / config-1 logic and its bench
// assumes fsc_regs.svh supplies the numeric constants
package fsc_pkg;
   // event handed from the link domain to the system domain
   typedef enum logic [1:0] {FSC_EV_NONE, FSC_EV_UNLOCK, FSC_EV_CLEAR, FSC_EV_WRITE} fsc_evt_t;
   // status reported by the array engine, same clock as the block
   typedef struct packed {
      logic busy;
      logic erase_start;
      logic erase_fail;
      logic erase_hits_protected;
      logic program_start;
      logic program_fail;
      logic program_hits_protected;
      logic region_valid;
      logic [1:0] region;
      logic erase_paused;
      logic program_paused;
   } fsc_core_t;
   // volatile first configuration register as seen by the rest of the device
   typedef struct packed {
      logic paused_state;
      logic complement_protect;
      logic [3:0] region_lock;
      logic four_lane;
      logic reg_lock_volatile;
   } fsc_cfg_t;
endpackage

//--- common/fsc_regs.svh
// register layout, command codes and reset values of the status-2 / config-1 logic
// assumes inclusion by its bare name; holds definitions only
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH
// ------------------------------------------------------------
// command opcodes seen on the serial link
// ------------------------------------------------------------
`define FSC_OP_READ_STATUS2 8'h07
`define FSC_OP_READ_ANY 8'h65
`define FSC_OP_WRITE_REGS 8'h01
`define FSC_OP_WRITE_ANY 8'h71
`define FSC_OP_NV_UNLOCK 8'h06
`define FSC_OP_CLEAR_STATUS 8'h30
// ------------------------------------------------------------
// read-any / write-any addresses
// ------------------------------------------------------------
`define FSC_ADDR_STATUS2 24'h000010
`define FSC_ADDR_CONFIG1_NV 24'h000020
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define FSC_ST2_ERASE_FAIL 6
`define FSC_ST2_PROG_FAIL 5
`define FSC_ST2_ERASE_PAUSED 1
`define FSC_ST2_PROG_PAUSED 0
`define FSC_CF1_PAUSED_DEF 7
`define FSC_CF1_CMP_DEF 6
`define FSC_CF1_LOCK_HI 5
`define FSC_CF1_LOCK_LO 2
`define FSC_CF1_QUAD_DEF 1
`define FSC_CF1_REGLOCK_DEF 0
// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define FSC_ST2_RESET 8'h00
`define FSC_CF1_NV_RESET 8'h00
`define FSC_PROTECT_MODE_OPEN 3'h7
`define FSC_BYTE_READ_ANY_REG_CMD_DATA 3'h4
`define FSC_BYTE_WRR_LAST 3'h2
`define FSC_BYTE_WRITE_ANY_REG_CMD_LAST 3'h4
`endif

//--- dv/fsc_host_model.sv
// host controller model: serial master that shifts one command frame at a time
// assumes a mode 0 link at 125 ns per bit; the clock is parked low between frames
`timescale 1ns/1ps
module fsc_host_model (
   // serial link
   output logic sck,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   logic [7:0] rx_byte; // last eight bits taken from miso
   event done; // fires once per finished frame
   // link idles deselected with the clock still
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // tx is left aligned; nbits from its top go out msb first
   task automatic frame(input logic [39:0] tx, input int nbits);
      #17.3 cs_n = 1'b0; // odd offset keeps the link out of phase with mclk
      for (int i = 0; i < nbits; i++) begin
         mosi = tx[39 - i]; // opcode leads, then the address and data bits the caller packed after it
         #62.5 sck = 1'b1;
         rx_byte = {rx_byte[6:0], miso};
         #62.5 sck = 1'b0;
      end
      #62.5 cs_n = 1'b1;
      // the released data line flips so that no stale level can pass as data
      mosi = ~mosi;
      ->done;
      #250;
   endtask
endmodule

//--- dv/fsc_status_cfg_tb.sv
// self-checking bench for the status-2 / config-1 block
// assumes the host model drives the link and the bench drives the core side
`timescale 1ns/1ps
`include "fsc_regs.svh"
module fsc_status_cfg_tb;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic mclk = 1'b0;
   logic reset, sck, cs_n, mosi, miso, soft_reset, op_busy_flag, region_refused;
   fsc_pkg::fsc_core_t core; // array engine status
   logic [2:0] protect_mode_field;
   fsc_pkg::fsc_cfg_t cfg_v; // volatile copy
   logic [7:0] st2, cf1, img, d; // img is the expected config image
   logic [7:0] exp_q[$]; // expected link read bytes, oldest first
   // erase fail, protected sector erase, chip erase hit, locked region 3 erase, program fail, protected program
   logic [11:0] fail_tab[6] = '{12'h200, 12'h500, 12'h900, 12'h41C, 12'h040, 12'h0A0};
   int miscompares = 0;
   int checks = 0;
   always #5 mclk = ~mclk;
   fsc_host_model i_host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   fsc_status_cfg i_dut (.mclk(mclk), .reset(reset), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .core(core), .protect_mode_field(protect_mode_field), .soft_reset(soft_reset),
      .config1_volatile_reg(cfg_v), .status2_volatile_reg(st2), .config1_nonvolatile_reg(cf1),
      .op_busy_flag(op_busy_flag), .region_refused(region_refused));
   // ------------------------------------------------------------
   // compare and stimulus tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: link read %h, expected %h", $time, got, exp);
      end
   endtask
   // port values are sampled at a falling edge, well away from updates
   task automatic cmp_port(input logic [7:0] exp, input logic [7:0] got);
      @(negedge mclk);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: port value %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [23:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      i_host.frame({`FSC_OP_READ_ANY, a, 8'h00}, 40);
   endtask
   // status 2 through both read opcodes
   task automatic rs(input logic [7:0] exp);
      exp_q.push_back(exp);
      i_host.frame({`FSC_OP_READ_STATUS2, 32'h0}, 16);
      rd(`FSC_ADDR_STATUS2, exp);
   endtask
   task automatic op(input logic [7:0] c);
      i_host.frame({c, 32'h0}, 8);
   endtask
   // unlock, then one write form; ok says whether the write should be taken
   task automatic wr(input logic [7:0] v, input logic any, input logic ok);
      op(`FSC_OP_NV_UNLOCK);
      if (any) i_host.frame({`FSC_OP_WRITE_ANY, `FSC_ADDR_CONFIG1_NV, v}, 40);
      else i_host.frame({`FSC_OP_WRITE_REGS, 8'h00, v, 16'h0}, 24);
      if (ok && !img[0]) img = {1'b0, v[6], img[5:2] | v[5:2], v[1],
         img[0] | (v[0] & (protect_mode_field == `FSC_PROTECT_MODE_OPEN))};
      cmp_port(img, cf1);
      rd(`FSC_ADDR_CONFIG1_NV, img);
   endtask
   task automatic pulse(input logic [11:0] v);
      @(negedge mclk) core = fsc_pkg::fsc_core_t'(v);
      @(negedge mclk) core = '0;
   endtask
   // ------------------------------------------------------------
   // monitor: each finished read frame takes the oldest note
   // ------------------------------------------------------------
   always @(i_host.done) if (exp_q.size() > 0) cmp_byte(exp_q.pop_front(), i_host.rx_byte);
   // watchdog sized well beyond the roughly 250 us of frames
   initial begin
      #800000;
      miscompares++;
      tally_and_finish();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      core = '0;
      protect_mode_field = 3'h0;
      soft_reset = 1'b0;
      reset = 1'b1;
      img = `FSC_CF1_NV_RESET;
      void'($urandom(68075));
      repeat (8) @(negedge mclk);
      reset = 1'b0;
      repeat (3) @(negedge mclk);
      rs(`FSC_ST2_RESET);
      rd(24'h000040, 8'h00); // unmapped address reads zero
      // suspend flags mirror the engine; a write aimed at status 2 does nothing
      for (int j = 1; j < 4; j++) begin
         @(negedge mclk) core = fsc_pkg::fsc_core_t'(j);
         op(`FSC_OP_NV_UNLOCK);
         i_host.frame({`FSC_OP_WRITE_ANY, `FSC_ADDR_STATUS2, 8'hFF}, 40);
         cmp_port({6'h0, j[1:0]}, st2);
         rs({6'h0, j[1:0]});
      end
      // a busy engine refuses the write and still uses up the unlock left by the loop
      @(negedge mclk) core = fsc_pkg::fsc_core_t'(12'h800);
      i_host.frame({`FSC_OP_WRITE_ANY, `FSC_ADDR_CONFIG1_NV, 8'hFF}, 40);
      @(negedge mclk) core = '0;
      cmp_port(8'h00, cf1);
      // write without unlock is ignored, then two real writes with lock bit 3 set
      i_host.frame({`FSC_OP_WRITE_ANY, `FSC_ADDR_CONFIG1_NV, 8'hFF}, 40);
      cmp_port(8'h00, cf1);
      wr(8'($urandom) | 8'h20, 1'b0, 1'b1);
      wr(8'($urandom), 1'b1, 1'b1);
      // each failure cause sets its flag, holds busy, blocks writes until cleared
      for (int k = 0; k < 7; k++) begin
         pulse(k < 6 ? fail_tab[k] : 12'h09C); // last entry programs locked region 3
         d = (k < 4) ? 8'h40 : 8'h20;
         cmp_port({7'h0, (k == 3 || k == 6)}, {7'h0, region_refused});
         cmp_port(d, st2);
         cmp_port(8'h01, {7'h0, op_busy_flag});
         wr(8'($urandom), k[0], 1'b0);
         rs(d);
         op(`FSC_OP_CLEAR_STATUS);
         cmp_port(8'h00, st2);
         cmp_port(8'h00, {7'h0, op_busy_flag});
      end
      // a soft reset copies the defaults into the volatile register
      @(negedge mclk) soft_reset = 1'b1;
      @(negedge mclk) soft_reset = 1'b0;
      cmp_port({1'b0, img[6:1], 1'b0}, {cfg_v[7:1], 1'b0});
      // register lock default, programmable only with the field open, then locks all
      protect_mode_field = 3'h7;
      wr(8'($urandom) | 8'h01, 1'b1, 1'b1);
      wr(~img, 1'b0, 1'b1);
      cmp_port(8'h01, {7'h0, cfg_v[0]});
      // second power-on reset in mid-run
      @(negedge mclk) reset = 1'b1;
      repeat (8) @(negedge mclk);
      reset = 1'b0;
      cmp_port(8'h00, cf1);
      cmp_port(8'h00, cfg_v);
      cmp_port(8'h00, st2);
      tally_and_finish();
   end
endmodule

//--- verilog/fsc_status_cfg.sv
// status register 2 and non-volatile config register 1 with a serial command front end
// assumes: single-lane serial link, mode 0, link clock stands still outside frames;
// core status arrives on mclk; reset is the power-on / hardware reset
//
// Behaviour
// - status2 read by read-status2 or read-any
// - status2 bits are hardware-set read-only status
// - status2 bits 7,4,3,2 read zero
// - erase fail sets bit 6, resets 0
// - erase of protected sector/region sets erase fail
// - chip erase hitting protection sets erase fail
// - program fail sets bit 5, resets 0
// - program of protected sector/region sets fail
// - only clear-status clears both fail flags
// - bit 1 mirrors erase paused mode
// - bit 0 mirrors program paused mode
// - config1 written by write-regs or write-any
// - config1 write needs prior nv unlock command
// - config bit 7 read-only zero
// - config bit 6 gives complement default
// - bits 5:2 one-time region locks
// - config bit 1 gives four-lane default
// - bit 0 programmable only when mode 111
// - bit 0 set locks registers forever; here the lock lasts only until reset clears the image
// - fail flag holds busy, refuses operations
// - volatile register lock loads from bit 0
`timescale 1ns/1ps
`include "fsc_regs.svh"
module fsc_status_cfg (
   // system clock and reset
   input wire logic mclk,
   input wire logic reset,
   // serial link
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   // array engine side
   input wire fsc_pkg::fsc_core_t core,
   input wire logic [2:0] protect_mode_field,
   input wire logic soft_reset,
   // state shown to the device
   output fsc_pkg::fsc_cfg_t config1_volatile_reg,
   output logic [7:0] status2_volatile_reg,
   output logic [7:0] config1_nonvolatile_reg,
   output logic op_busy_flag,
   output logic region_refused
);
   // ------------------------------------------------------------
   // link domain: bit and byte counting
   // ------------------------------------------------------------
   logic [2:0] bit_cnt_ff; // bit within current byte
   logic [2:0] byte_cnt_ff; // bytes done, saturates at 7
   logic [6:0] sh_in_ff; // incoming bits of current byte
   logic [7:0] opcode_ff; // first byte of the frame
   logic [23:0] addr_ff; // address of read-any / write-any
   logic [7:0] in_byte; // byte completing on this edge
   logic byte_done; // last bit of a byte arrives
   assign in_byte = {sh_in_ff, mosi};
   assign byte_done = (bit_cnt_ff == 3'h7);

   // counters restart whenever the frame ends; sck may never tick again
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt_ff <= 3'h0;
         byte_cnt_ff <= 3'h0;
      end else begin
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         if (byte_done && byte_cnt_ff != 3'h7) begin
            byte_cnt_ff <= byte_cnt_ff + 3'h1;
         end
      end
   end

   // shift register, opcode and address capture
   always_ff @(posedge sck) begin
      sh_in_ff <= in_byte[6:0];
      if (byte_done && byte_cnt_ff == 3'h0) begin
         opcode_ff <= in_byte;
      end
      if (byte_done && byte_cnt_ff >= 3'h1 && byte_cnt_ff <= 3'h3) begin
         addr_ff <= {addr_ff[15:0], in_byte};
      end
   end

   // ------------------------------------------------------------
   // link domain: command decode into one event per frame
   // ------------------------------------------------------------
   logic is_unlock; // nv unlock opcode completes
   logic is_clear; // clear-status opcode completes
   logic is_wrr; // second data byte of write-regs completes
   logic is_write_any_reg_cmd; // data byte of write-any to config1 completes
   logic evt_req_ff; // level request to the system domain
   fsc_pkg::fsc_evt_t evt_code_ff; // held while the request stands
   logic [7:0] evt_data_ff; // data byte of a write event
   assign is_unlock = byte_done && byte_cnt_ff == 3'h0 && in_byte == `FSC_OP_NV_UNLOCK;
   assign is_clear = byte_done && byte_cnt_ff == 3'h0 && in_byte == `FSC_OP_CLEAR_STATUS;
   // first data byte of write-regs belongs to status 1 and is not handled here
   assign is_wrr = byte_done && byte_cnt_ff == `FSC_BYTE_WRR_LAST && opcode_ff == `FSC_OP_WRITE_REGS;
   assign is_write_any_reg_cmd = byte_done && byte_cnt_ff == `FSC_BYTE_WRITE_ANY_REG_CMD_LAST && opcode_ff == `FSC_OP_WRITE_ANY
                    && addr_ff == `FSC_ADDR_CONFIG1_NV;

   // request rises once per frame and falls when the frame ends
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         evt_req_ff <= 1'b0;
      end else if (is_unlock || is_clear || is_wrr || is_write_any_reg_cmd) begin
         evt_req_ff <= 1'b1;
      end
   end

   // payload is written on the same sck edge that raises the request and then left alone
   always_ff @(posedge sck) begin
      if (is_unlock) begin
         evt_code_ff <= fsc_pkg::FSC_EV_UNLOCK;
      end else if (is_clear) begin
         evt_code_ff <= fsc_pkg::FSC_EV_CLEAR;
      end else if (is_wrr || is_write_any_reg_cmd) begin
         evt_code_ff <= fsc_pkg::FSC_EV_WRITE;
         evt_data_ff <= in_byte;
      end
   end

   // ------------------------------------------------------------
   // link domain: read data out on the falling edge
   // ------------------------------------------------------------
   logic [7:0] snap_st2_ff; // frozen copies written by the system domain
   logic [7:0] snap_cf1_ff;
   logic rd_st2; // read-status2 data phase
   logic rd_any; // read-any data phase
   logic [7:0] rd_any_byte; // byte picked by the read-any address
   logic [7:0] rd_byte; // byte to start sending
   logic [6:0] out_sh_ff; // remaining bits of the byte in flight
   logic miso_ff;
   assign rd_st2 = opcode_ff == `FSC_OP_READ_STATUS2 && byte_cnt_ff != 3'h0;
   assign rd_any = opcode_ff == `FSC_OP_READ_ANY && byte_cnt_ff >= `FSC_BYTE_READ_ANY_REG_CMD_DATA;
   // unmapped read-any addresses answer zero
   assign rd_any_byte = (addr_ff == `FSC_ADDR_STATUS2) ? snap_st2_ff :
                        (addr_ff == `FSC_ADDR_CONFIG1_NV) ? snap_cf1_ff : 8'h00;
   assign rd_byte = rd_st2 ? snap_st2_ff : (rd_any ? rd_any_byte : 8'h00);

   // a new byte loads at each byte boundary, so reads repeat the register
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         miso_ff <= 1'b0;
         out_sh_ff <= 7'h00;
      end else if (bit_cnt_ff == 3'h0) begin
         miso_ff <= rd_byte[7];
         out_sh_ff <= rd_byte[6:0];
      end else begin
         miso_ff <= out_sh_ff[6];
         out_sh_ff <= {out_sh_ff[5:0], 1'b0};
      end
   end
   assign miso = miso_ff;

   // ------------------------------------------------------------
   // crossing into the system domain
   // ------------------------------------------------------------
   logic req_s1_ff, req_s2_ff, req_d_ff; // request synchroniser and edge memory
   logic sel_s1_ff, sel_s2_ff; // frame-active synchroniser
   logic evt_pulse; // one mclk pulse per link event
   logic ev_unlock, ev_clear, ev_write;
   assign evt_pulse = req_s2_ff && !req_d_ff;
   assign ev_unlock = evt_pulse && evt_code_ff == fsc_pkg::FSC_EV_UNLOCK;
   assign ev_clear = evt_pulse && evt_code_ff == fsc_pkg::FSC_EV_CLEAR;
   assign ev_write = evt_pulse && evt_code_ff == fsc_pkg::FSC_EV_WRITE;

   // two flops before any use of the request and frame-active levels
   always_ff @(posedge mclk) begin
      if (reset) begin
         req_s1_ff <= 1'b0;
         req_s2_ff <= 1'b0;
         req_d_ff <= 1'b0;
         sel_s1_ff <= 1'b0;
         sel_s2_ff <= 1'b0;
      end else begin
         req_s1_ff <= evt_req_ff;
         req_s2_ff <= req_s1_ff;
         req_d_ff <= req_s2_ff;
         sel_s1_ff <= !cs_n;
         sel_s2_ff <= sel_s1_ff;
      end
   end

   // snapshots only move between frames; a read sees one consistent value
   always_ff @(posedge mclk) begin
      if (reset) begin
         snap_st2_ff <= `FSC_ST2_RESET;
         snap_cf1_ff <= `FSC_CF1_NV_RESET;
      end else if (!sel_s2_ff) begin
         snap_st2_ff <= status2_volatile_reg;
         snap_cf1_ff <= config1_nonvolatile_reg;
      end
   end

   // ------------------------------------------------------------
   // status register 2
   // ------------------------------------------------------------
   logic erase_fail_ff, prog_fail_ff, erase_paused_ff, prog_paused_ff;
   logic region_locked; // target region's lock bit is set
   logic erase_err_set, prog_err_set;
   logic [7:0] st2_ff;
   logic [7:0] nv_ff; // non-volatile config register 1
   assign region_locked = core.region_valid && nv_ff[`FSC_CF1_LOCK_LO + core.region];
   assign erase_err_set = core.erase_fail
                          || (core.erase_start && (core.erase_hits_protected || region_locked))
                          || (core.busy && core.erase_hits_protected);
   assign prog_err_set = core.program_fail
                         || (core.program_start && (core.program_hits_protected || region_locked));

   // set wins over a clear arriving in the same cycle; writes never reach these
   always_ff @(posedge mclk) begin
      if (reset) begin
         erase_fail_ff <= 1'b0;
         prog_fail_ff <= 1'b0;
      end else begin
         erase_fail_ff <= (erase_fail_ff && !ev_clear) || erase_err_set;
         prog_fail_ff <= (prog_fail_ff && !ev_clear) || prog_err_set;
      end
   end

   // paused bits follow the engine, registered for a flop-driven output
   always_ff @(posedge mclk) begin
      if (reset) begin
         erase_paused_ff <= 1'b0;
         prog_paused_ff <= 1'b0;
      end else begin
         erase_paused_ff <= core.erase_paused;
         prog_paused_ff <= core.program_paused;
      end
   end

   // reserved bits are constant zero in the assembled register
   always_comb begin
      st2_ff = `FSC_ST2_RESET;
      st2_ff[`FSC_ST2_ERASE_FAIL] = erase_fail_ff;
      st2_ff[`FSC_ST2_PROG_FAIL] = prog_fail_ff;
      st2_ff[`FSC_ST2_ERASE_PAUSED] = erase_paused_ff;
      st2_ff[`FSC_ST2_PROG_PAUSED] = prog_paused_ff;
   end
   assign status2_volatile_reg = st2_ff;

   // ------------------------------------------------------------
   // config register 1: write gating and non-volatile image
   // ------------------------------------------------------------
   logic wel_ff; // unlock latch for the non-volatile write
   logic regs_locked; // volatile or permanent register lock
   logic write_ok; // a write event that may change the image
   logic [7:0] nxt_nv;
   assign regs_locked = config1_volatile_reg.reg_lock_volatile || nv_ff[`FSC_CF1_REGLOCK_DEF];
   assign write_ok = ev_write && wel_ff && !regs_locked
                     && !erase_fail_ff && !prog_fail_ff && !core.busy;

   // new image: one-time bits only OR in, bit 7 never written
   always_comb begin
      nxt_nv = nv_ff;
      nxt_nv[`FSC_CF1_PAUSED_DEF] = 1'b0;
      nxt_nv[`FSC_CF1_CMP_DEF] = evt_data_ff[`FSC_CF1_CMP_DEF];
      nxt_nv[`FSC_CF1_LOCK_HI:`FSC_CF1_LOCK_LO] = nv_ff[`FSC_CF1_LOCK_HI:`FSC_CF1_LOCK_LO]
         | evt_data_ff[`FSC_CF1_LOCK_HI:`FSC_CF1_LOCK_LO];
      nxt_nv[`FSC_CF1_QUAD_DEF] = evt_data_ff[`FSC_CF1_QUAD_DEF];
      nxt_nv[`FSC_CF1_REGLOCK_DEF] = nv_ff[`FSC_CF1_REGLOCK_DEF]
         | (evt_data_ff[`FSC_CF1_REGLOCK_DEF] && protect_mode_field == `FSC_PROTECT_MODE_OPEN);
   end

   // reset stands for power-on here: no real cell behind the image
   always_ff @(posedge mclk) begin
      if (reset) begin
         nv_ff <= `FSC_CF1_NV_RESET;
      end else if (write_ok) begin
         nv_ff <= nxt_nv;
      end
   end

   // unlock is consumed by any config1 write attempt, taken or refused
   always_ff @(posedge mclk) begin
      if (reset) begin
         wel_ff <= 1'b0;
      end else if (ev_unlock) begin
         wel_ff <= 1'b1;
      end else if (ev_write) begin
         wel_ff <= 1'b0;
      end
   end
   assign config1_nonvolatile_reg = nv_ff;

   // ------------------------------------------------------------
   // volatile copies and busy
   // ------------------------------------------------------------
   fsc_pkg::fsc_cfg_t cfg_ff;
   logic busy_ff, refused_ff;

   // software reset reloads defaults but keeps the register lock
   always_ff @(posedge mclk) begin
      if (reset) begin
         cfg_ff <= '0;
      end else begin
         cfg_ff.paused_state <= core.erase_paused || core.program_paused;
         cfg_ff.region_lock <= nv_ff[`FSC_CF1_LOCK_HI:`FSC_CF1_LOCK_LO];
         if (soft_reset) begin
            cfg_ff.complement_protect <= nv_ff[`FSC_CF1_CMP_DEF];
            cfg_ff.four_lane <= nv_ff[`FSC_CF1_QUAD_DEF];
         end
         // hard reset always leaves the lock at zero, equal to the image
         if (nv_ff[`FSC_CF1_REGLOCK_DEF]) begin
            cfg_ff.reg_lock_volatile <= 1'b1;
         end
      end
   end
   assign config1_volatile_reg = cfg_ff;

   // busy holds while a fail flag stands; refused marks locked-region hits
   always_ff @(posedge mclk) begin
      if (reset) begin
         busy_ff <= 1'b0;
         refused_ff <= 1'b0;
      end else begin
         busy_ff <= core.busy || erase_err_set || prog_err_set
                    || ((erase_fail_ff || prog_fail_ff) && !ev_clear);
         refused_ff <= (core.erase_start || core.program_start) && region_locked;
      end
   end
   assign op_busy_flag = busy_ff;
   assign region_refused = refused_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_erase_prot_sets: assert property (@(posedge mclk) disable iff (reset)
      core.erase_start && region_locked |=> erase_fail_ff) else $error("locked erase left flag clear");
   chk_chip_erase_hit: assert property (@(posedge mclk) disable iff (reset)
      core.busy && core.erase_hits_protected |=> status2_volatile_reg[6]) else $error("chip erase hit lost");
   chk_prog_fail_sets: assert property (@(posedge mclk) disable iff (reset)
      core.program_fail |=> status2_volatile_reg[5] && op_busy_flag) else $error("program fail not seen");
   chk_flags_clear_only: assert property (@(posedge mclk) disable iff (reset)
      $fell(erase_fail_ff) || $fell(prog_fail_ff) |-> $past(ev_clear)) else $error("flag cleared without clear");
   chk_reserved_zero: assert property (@(posedge mclk) disable iff (reset)
      (status2_volatile_reg & 8'h9C) == 8'h00) else $error("reserved status bit set");
   chk_paused_mirror: assert property (@(posedge mclk) disable iff (reset)
      ##1 status2_volatile_reg[1] == $past(core.erase_paused)) else $error("erase paused mismatch");
   chk_otp_monotone: assert property (@(posedge mclk) disable iff (reset)
      ##1 ($past(nv_ff) & 8'h3D & ~nv_ff) == 8'h00) else $error("one-time bit returned to zero");
   chk_reglock_mode: assert property (@(posedge mclk) disable iff (reset)
      $rose(nv_ff[0]) |-> $past(protect_mode_field) == 3'h7) else $error("lock default set in wrong mode");
   chk_locked_stable: assert property (@(posedge mclk) disable iff (reset)
      ev_write && nv_ff[0] |=> $stable(nv_ff)) else $error("write passed permanent lock");
   chk_busy_holds: assert property (@(posedge mclk) disable iff (reset)
      (erase_fail_ff || prog_fail_ff) && !ev_clear |=> op_busy_flag ##1 (op_busy_flag || $past(ev_clear)))
      else $error("busy dropped with fail");
   chk_paused_def_zero: assert property (@(posedge mclk) disable iff (reset)
      !config1_nonvolatile_reg[7]) else $error("paused default bit set");
endmodule
